// ===== hw/mbfs_consts.vh
`ifndef MBFS_CONSTS_VH
`define MBFS_CONSTS_VH
`define MBFS_FC_RD_HOLD     8'h03
`define MBFS_FC_RD_INPUT    8'h04
`define MBFS_FC_DIAG        8'h08
`define MBFS_FC_WR_HOLD     8'h10
`define MBFS_EXC_FLAG       8'h80
`define MBFS_EXC_ILL_FUNC   8'h01
`define MBFS_EXC_ILL_ADDR   8'h02
`define MBFS_EXC_ILL_VALUE  8'h03
`define MBFS_EXC_DEV_FAIL   8'h05
`define MBFS_ADDR_MAX       8'hf7
`define MBFS_CRC_INIT       16'hffff
`define MBFS_CRC_POLY       16'ha001
`define MBFS_BUF_BYTES      256
`endif

// ===== hw/mbfs_crc16.v
`timescale 1ns/10ps
`include "mbfs_consts.vh"
// Byte-serial CRC-16 over the frame, one byte per cycle
module mbfs_crc16 (
   input  wire        clk_sys,
   input  wire        rst_n,
   input  wire        clr,
   input  wire        en,
   input  wire [7:0]  data,
   output wire [15:0] crc
);
   reg [15:0] crc_q;

   function [15:0] crc_byte;
      input [15:0] c;
      input [7:0]  b;
      integer      i;
      reg   [15:0] t;
      begin
         t = c ^ {8'h00, b};
         for (i = 0; i < 8; i = i + 1) begin
            if (t[0])
               t = (t >> 1) ^ `MBFS_CRC_POLY;
            else
               t = t >> 1;
         end
         crc_byte = t;
      end
   endfunction

   always @(posedge clk_sys) begin
      if (!rst_n || clr)
         crc_q <= `MBFS_CRC_INIT;
      else if (en)
         crc_q <= crc_byte(crc_q, data);
   end

   assign crc = crc_q;
endmodule // mbfs_crc16

// ===== hw/mbfs_slave.v
`timescale 1ns/10ps
`include "mbfs_consts.vh"
// Functional notes
// - Answer only own address, range 1..247
// - Address zero broadcast is ignored
// - Only functions 3, 4, 8, 16 supported
// - Check value sent low byte first
// - Faulty frames dropped with no reply
// - Read reply: address, function, count, data, check
// - Byte count equals data bytes following
// - Registers ascending, high byte first
// - Exception reply sets function code MSB
// - Exception: address, function, code, check
// - Function 4 reads input register space
// - Function 3 reads holding register space
// - Odd address or count gives exception
// - Floats occupy two registers, never split
// - Lower register carries upper float half
// - Exception codes 01, 02, 03, 05
// - Write reply echoes address, start, count
module mbfs_slave #(
   parameter MAX_REGS = 16'd64
) (
   input  wire        clk_sys,
   input  wire        rst_n,
   input  wire [7:0]  own_addr,
   input  wire        rx_valid,
   input  wire [7:0]  rx_data,
   input  wire        rx_fault,
   input  wire        frame_end,
   output wire        tx_valid,
   output reg  [7:0]  tx_data,
   output reg         tx_last,
   input  wire        tx_ready,
   output reg         rd_req,
   output reg         rd_input_space,
   output reg  [15:0] rd_addr,
   input  wire [31:0] rd_float,
   input  wire        rd_ok,
   output reg         wr_req,
   output reg  [15:0] wr_addr,
   output reg  [31:0] wr_float,
   input  wire [1:0]  wr_status,
   output wire        busy
);
   localparam S_RX   = 4'b0001;
   localparam S_EXEC = 4'b0010;
   localparam S_TX   = 4'b0100;
   localparam S_CRC  = 4'b1000;

   reg [3:0]  state_q;
   reg [7:0]  buf_q [0:`MBFS_BUF_BYTES-1];
   reg [8:0]  rx_cnt_q;
   reg        bad_q;
   reg [8:0]  tx_idx_q;
   reg [8:0]  tx_len_q;
   reg [1:0]  crc_ph_q;
   reg        wait_q;
   reg [15:0] crc_fin;
   reg [7:0]  crc_hi_q;
   wire [15:0] crc_rx;
   wire [15:0] crc_tx;
   reg         crc_clr;

   wire [7:0]  q_fc    = buf_q[1];
   wire [15:0] q_start = {buf_q[2], buf_q[3]};
   wire [15:0] q_count = {buf_q[4], buf_q[5]};
   wire        q_addr_ok = (buf_q[0] == own_addr) && (own_addr != 8'h00)
                           && (own_addr <= `MBFS_ADDR_MAX);

   // Receive CRC runs over every byte; residue zero means check passed
   mbfs_crc16 u_crc_rx (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .clr     (crc_clr),
      .en      (state_q == S_RX && rx_valid),
      .data    (rx_data),
      .crc     (crc_rx)
   );

   wire tx_fire = tx_valid && tx_ready;
   mbfs_crc16 u_crc_tx (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .clr     (crc_clr),
      .en      (tx_fire && state_q == S_TX),
      .data    (tx_data),
      .crc     (crc_tx)
   );

   assign tx_valid = (state_q == S_TX && !wait_q) || state_q == S_CRC;
   assign busy     = state_q != S_RX;
   // Only a good read reply is longer than six bytes
   wire rd_reply = (tx_len_q > 9'd6) && !buf_q[1][7];

   always @* begin
      crc_clr = (state_q == S_RX && frame_end) || (state_q == S_CRC && tx_fire && crc_ph_q == 2'd1);
   end

   always @(posedge clk_sys) begin
      if (!rst_n) begin
         state_q        <= S_RX;
         rx_cnt_q       <= 9'h000;
         bad_q          <= 1'b0;
         tx_idx_q       <= 9'h000;
         tx_len_q       <= 9'h000;
         crc_ph_q       <= 2'd0;
         wait_q         <= 1'b0;
         tx_data        <= 8'h00;
         tx_last        <= 1'b0;
         rd_req         <= 1'b0;
         rd_input_space <= 1'b0;
         rd_addr        <= 16'h0000;
         wr_req         <= 1'b0;
         wr_addr        <= 16'h0000;
         wr_float       <= 32'h00000000;
      end else begin
         rd_req <= 1'b0;
         wr_req <= 1'b0;
         case (state_q)
            S_RX: begin
               if (rx_valid) begin
                  if (rx_cnt_q < `MBFS_BUF_BYTES)
                     buf_q[rx_cnt_q[7:0]] <= rx_data;
                  else
                     bad_q <= 1'b1;
                  rx_cnt_q <= rx_cnt_q + 9'd1;
               end
               if (rx_fault)
                  bad_q <= 1'b1;
               if (frame_end) begin
                  rx_cnt_q <= 9'h000;
                  bad_q    <= 1'b0;
                  if (!bad_q && !rx_fault && rx_cnt_q >= 9'd4 && crc_rx == 16'h0000 && q_addr_ok)
                     state_q <= S_EXEC;
                  else
                     state_q <= S_RX;
               end
            end
            S_EXEC: begin
               // Response header reuses buffer bytes 0 and 1
               tx_idx_q <= 9'h000;
               crc_ph_q <= 2'd0;
               wait_q   <= 1'b0;
               tx_data  <= buf_q[0];
               tx_last  <= 1'b0;
               state_q  <= S_TX;
               if (q_fc == `MBFS_FC_RD_HOLD || q_fc == `MBFS_FC_RD_INPUT) begin
                  if (q_start[0] || q_count[0] || q_count == 16'h0000 || q_count > MAX_REGS) begin
                     buf_q[1] <= q_fc | `MBFS_EXC_FLAG;
                     buf_q[2] <= `MBFS_EXC_ILL_ADDR;
                     tx_len_q <= 9'd3;
                  end else begin
                     buf_q[2] <= {q_count[6:0], 1'b0};
                     tx_len_q <= 9'd3 + {q_count[7:0], 1'b0};
                     rd_input_space <= (q_fc == `MBFS_FC_RD_INPUT);
                     rd_addr  <= q_start;
                  end
               end else if (q_fc == `MBFS_FC_WR_HOLD) begin
                  if (q_start[0] || q_count != 16'd2 || buf_q[6] != 8'h04) begin
                     buf_q[1] <= q_fc | `MBFS_EXC_FLAG;
                     buf_q[2] <= `MBFS_EXC_ILL_ADDR;
                     tx_len_q <= 9'd3;
                  end else begin
                     wr_req   <= 1'b1;
                     wr_addr  <= q_start;
                     wr_float <= {buf_q[7], buf_q[8], buf_q[9], buf_q[10]};
                     tx_len_q <= 9'd6;
                     wait_q   <= 1'b1;
                  end
               end else if (q_fc == `MBFS_FC_DIAG) begin
                  tx_len_q <= 9'd6; // Diagnostic echo of sub-function and data
               end else begin
                  buf_q[1] <= q_fc | `MBFS_EXC_FLAG;
                  buf_q[2] <= `MBFS_EXC_ILL_FUNC;
                  tx_len_q <= 9'd3;
               end
            end
            S_TX: begin
               if (wait_q) begin
                  // Write result or fetched float lands one cycle after its request
                  wait_q <= 1'b0;
                  if (buf_q[1] == `MBFS_FC_WR_HOLD && wr_status != 2'd0) begin
                     buf_q[1] <= buf_q[1] | `MBFS_EXC_FLAG;
                     buf_q[2] <= (wr_status == 2'd1) ? `MBFS_EXC_ILL_VALUE : `MBFS_EXC_DEV_FAIL;
                     tx_len_q <= 9'd3;
                  end
               end else if (tx_fire) begin
                  tx_idx_q <= tx_idx_q + 9'd1;
                  if (tx_idx_q + 9'd1 == tx_len_q) begin
                     state_q <= S_CRC;
                     tx_data <= crc_tx_next_lo(crc_tx, tx_data);
                  end else if (tx_idx_q >= 9'd2 && rd_reply) begin
                     // Data bytes: float high word first, ascending pairs
                     tx_data <= data_byte(tx_idx_q[1:0]);
                     if (tx_idx_q[1:0] == 2'd1 && tx_idx_q + 9'd2 < tx_len_q) begin
                        // Next float fetched while the last byte of this one waits
                        rd_req  <= 1'b1;
                        wait_q  <= 1'b1;
                        rd_addr <= rd_addr + 16'd2;
                     end
                  end else begin
                     tx_data <= buf_q[tx_idx_q[7:0] + 8'd1];
                     if (tx_idx_q == 9'd1 && rd_reply) begin
                        // First float fetched as the byte count goes out
                        rd_req <= 1'b1;
                        wait_q <= 1'b1;
                     end
                  end
               end
            end
            S_CRC: begin
               if (tx_fire) begin
                  crc_ph_q <= crc_ph_q + 2'd1;
                  tx_data  <= crc_hi_q;
                  tx_last  <= 1'b1;
                  if (crc_ph_q == 2'd1) begin
                     state_q <= S_RX;
                     tx_last <= 1'b0;
                  end
               end
            end
            default: state_q <= S_RX;
         endcase
      end
   end

   // Final CRC captured with the last payload byte folded in
   always @(posedge clk_sys) begin
      if (!rst_n)
         crc_hi_q <= 8'h00;
      else if (state_q == S_TX && tx_fire && tx_idx_q + 9'd1 == tx_len_q)
         crc_hi_q <= crc_fin[15:8];
   end
   always @* begin
      crc_fin = crc_tx_full(crc_tx, tx_data);
   end

   function [15:0] crc_tx_full;
      input [15:0] c;
      input [7:0]  b;
      integer      i;
      reg   [15:0] t;
      begin
         t = c ^ {8'h00, b};
         for (i = 0; i < 8; i = i + 1) begin
            if (t[0])
               t = (t >> 1) ^ `MBFS_CRC_POLY;
            else
               t = t >> 1;
         end
         crc_tx_full = t;
      end
   endfunction

   function [7:0] crc_tx_next_lo;
      input [15:0] c;
      input [7:0]  b;
      reg   [15:0] t;
      begin
         t = crc_tx_full(c, b);
         crc_tx_next_lo = t[7:0];
      end
   endfunction

   // Float byte select, sign/exponent byte first
   function [7:0] data_byte;
      input [1:0] ph;
      begin
         case (ph)
            2'd2: data_byte = rd_ok ? rd_float[31:24] : 8'h00;
            2'd3: data_byte = rd_float[23:16];
            2'd0: data_byte = rd_float[15:8];
            default: data_byte = rd_float[7:0];
         endcase
      end
   endfunction
endmodule // mbfs_slave

// ===== dv/mbfs_chk.sv
`timescale 1ns/10ps
module mbfs_chk #(parameter MAX_REGS = 16'd64) (
   input wire        clk_sys,
   input wire        rst_n,
   input wire [7:0]  own_addr,
   input wire        tx_valid,
   input wire [7:0]  tx_data,
   input wire        tx_last,
   input wire        tx_ready,
   input wire        rd_req,
   input wire [15:0] rd_addr,
   input wire        busy
);
   reg  [3:0] idx_q;
   reg  [7:0] fc_q;
   wire       acc = tx_valid && tx_ready;
   // Byte position within the reply
   always @(posedge clk_sys) begin
      if (!rst_n || (acc && tx_last)) idx_q <= 4'h0;
      else if (acc && idx_q != 4'hf) idx_q <= idx_q + 4'h1;
      if (acc && idx_q == 4'h1) fc_q <= tx_data;
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   property p_first; tx_valid && idx_q == 4'h0 |-> tx_data == own_addr; endproperty
   a_first: assert property (p_first) else $error("reply not from own address");
   property p_zero; own_addr == 8'h00 || own_addr > 8'hf7 |-> !tx_valid; endproperty
   a_zero: assert property (p_zero) else $error("reply with invalid own address");
   property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data); endproperty
   a_hold: assert property (p_hold) else $error("stalled byte changed");
   property p_end; acc && tx_last |=> !tx_valid; endproperty
   a_end: assert property (p_end) else $error("bytes after check value");
   property p_exclen; tx_valid && idx_q == 4'h4 && fc_q[7] |-> tx_last; endproperty
   a_exclen: assert property (p_exclen) else $error("exception reply length");
   property p_exccode; tx_valid && idx_q == 4'h2 && fc_q[7] |-> tx_data inside {1, 2, 3, 5}; endproperty
   a_exccode: assert property (p_exccode) else $error("bad exception code");
   property p_bcount;
      tx_valid && idx_q == 4'h2 && fc_q inside {3, 4} |-> tx_data[1:0] == 2'h0 && tx_data <= 2 * MAX_REGS;
   endproperty
   a_bcount: assert property (p_bcount) else $error("bad byte count");
   property p_even; rd_req |-> !rd_addr[0] && busy; endproperty
   a_even: assert property (p_even) else $error("odd float fetch");
   property p_busy; tx_valid |-> busy; endproperty
   a_busy: assert property (p_busy) else $error("reply while idle");
   property p_done; tx_valid && idx_q == 4'h0 |-> ##[0:600] (acc && tx_last); endproperty
   a_done: assert property (p_done) else $error("reply never completed");
   c_read: cover property (acc && tx_last && fc_q == 8'h04);
   c_exc: cover property (acc && tx_last && fc_q[7]);
   c_stall: cover property (tx_valid && !tx_ready);
endmodule // mbfs_chk
bind mbfs_slave mbfs_chk #(.MAX_REGS(MAX_REGS)) u_chk (.clk_sys, .rst_n, .own_addr, .tx_valid, .tx_data,
   .tx_last, .tx_ready, .rd_req, .rd_addr, .busy);

// ===== dv/mbfs_master_model.sv
`timescale 1ns/10ps
module mbfs_master_model (
   input  wire       clk_sys,
   output reg        rx_valid = 1'b0,
   output reg  [7:0] rx_data = 8'h00,
   output reg        rx_fault = 1'b0,
   output reg        frame_end = 1'b0,
   output reg        tx_ready = 1'b0
);
   function automatic logic [15:0] crc(input logic [7:0] q[$]);
      logic [15:0] c;
      c = 16'hffff;
      foreach (q[i]) begin
         c = c ^ {8'h00, q[i]};
         repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
      end
      return c;
   endfunction
   // Mode 1 spoils the check value, mode 2 flags a line fault
   task automatic send(input logic [7:0] q[$], input int md);
      logic [15:0] c;
      c = crc(q);
      q.push_back(c[7:0]);
      q.push_back(c[15:8] ^ {7'h00, md == 1});
      foreach (q[i]) begin
         @(negedge clk_sys);
         rx_valid = 1'b1;
         rx_data = q[i];
         rx_fault = md == 2 && i == 2;
         @(negedge clk_sys);
         rx_valid = 1'b0;
         rx_fault = 1'b0;
         rx_data = ~rx_data;
      end
      repeat (4) @(negedge clk_sys);
      frame_end = 1'b1;
      @(negedge clk_sys);
      frame_end = 1'b0;
   endtask
   always @(negedge clk_sys) tx_ready <= $urandom_range(3) != 0;
endmodule // mbfs_master_model

// ===== dv/mbfs_tb.sv
`timescale 1ns/10ps
module testbench;
   reg          clk_sys = 1'b0;
   reg          rst_n = 1'b0;
   reg  [7:0]   own_addr = 8'h11;
   reg  [31:0]  rd_float = 32'h0;
   reg          rd_ok = 1'b0;
   reg  [1:0]   wr_status = 2'h0;
   reg  [15:0]  wa;
   reg  [31:0]  wf;
   wire         rx_valid, rx_fault, frame_end, tx_ready, tx_valid, tx_last;
   wire         rd_req, rd_input_space, wr_req, busy;
   wire [7:0]   rx_data, tx_data;
   wire [15:0]  rd_addr, wr_addr;
   wire [31:0]  wr_float;
   int          failures = 0;
   int          checks_done = 0;
   logic [7:0]  rxq[$], e[$];
   logic [7:0]  bad_fc[4] = '{8'h01, 8'h05, 8'h06, 8'h7f};
   always #2 clk_sys = ~clk_sys;
   mbfs_master_model m (.clk_sys, .rx_valid, .rx_data, .rx_fault, .frame_end, .tx_ready);
   mbfs_slave #(.MAX_REGS(16'd64)) dut (.clk_sys, .rst_n, .own_addr, .rx_valid, .rx_data, .rx_fault,
      .frame_end, .tx_valid, .tx_data, .tx_last, .tx_ready, .rd_req, .rd_input_space, .rd_addr,
      .rd_float, .rd_ok, .wr_req, .wr_addr, .wr_float, .wr_status, .busy);
   function automatic logic [31:0] fval(input logic sp, input logic [15:0] a);
      return {a ^ (sp ? 16'h4300 : 16'h3f00), ~a};
   endfunction
   // Parameter store behind the fetch and write strobes
   always @(posedge clk_sys) begin
      if (rd_req) rd_float <= fval(rd_input_space, rd_addr);
      if (rd_req) rd_ok <= 1'b1;
      if (wr_req) wa <= wr_addr;
      if (wr_req) wf <= wr_float;
      if (tx_valid && tx_ready) rxq.push_back(tx_data);
   end
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic run(input logic [7:0] q[$], input logic [7:0] x[$], input int md);
      logic [15:0] c;
      int n;
      rxq = {};
      m.send(q, md);
      c = m.crc(x);
      if (x.size() != 0) x = {x, c[7:0], c[15:8]};
      n = 0;
      repeat (4) @(negedge clk_sys);
      while (busy !== 1'b0 && n < 2000) begin
         @(negedge clk_sys);
         n++;
      end
      check("reply done", n < 2000, 1);
      check("reply length", rxq.size(), x.size());
      foreach (x[i]) if (i < rxq.size()) check("reply byte", rxq[i], x[i]);
   endtask
   task automatic rd(input logic [7:0] fc, input logic [15:0] s, input logic [15:0] n);
      logic [31:0] f;
      e = {own_addr, fc};
      if (s[0] || n[0] || n > 16'd64) e = {own_addr, fc | 8'h80, 8'h02};
      else begin
         e.push_back(n[7:0] << 1);
         for (int k = 0; k < n; k += 2) begin
            f = fval(fc == 8'h04, s + 16'(k));
            e = {e, f[31:24], f[23:16], f[15:8], f[7:0]};
         end
      end
      run({own_addr, fc, s[15:8], s[7:0], n[15:8], n[7:0]}, e, 0);
   endtask
   task automatic finish_test;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      #200000;
      failures++;
      finish_test();
   end
   initial begin
      void'($urandom(32'he466c59f));
      repeat (20) @(negedge clk_sys);
      rst_n = 1'b1;
      own_addr = 8'($urandom_range(247, 1));
      rd(8'h04, 16'h0000, 16'h0002);
      rd(8'h03, 16'h0004, 16'h0004);
      rd(8'h04, 16'h0003, 16'h0002);
      rd(8'h03, 16'h0002, 16'h0003);
      rd(8'h04, 16'h0000, 16'h0042);
      repeat (6) rd(8'($urandom_range(4, 3)), 16'($urandom_range(60) * 2), 16'($urandom_range(4, 1) * 2));
      foreach (bad_fc[i]) run({own_addr, bad_fc[i], 8'h00, 8'h00, 8'h00, 8'h02},
         {own_addr, bad_fc[i] | 8'h80, 8'h01}, 0);
      run({own_addr, 8'h08, 8'h00, 8'h00, 8'ha5, 8'h5a}, {own_addr, 8'h08, 8'h00, 8'h00, 8'ha5, 8'h5a}, 0);
      for (int w = 0; w < 3; w++) begin
         wr_status = 2'(w);
         e = {own_addr, 8'h90, (w == 1) ? 8'h03 : 8'h05};
         if (w == 0) e = {own_addr, 8'h10, 8'h00, 8'h02, 8'h00, 8'h02};
         run({own_addr, 8'h10, 8'h00, 8'h02, 8'h00, 8'h02, 8'h04, 8'h42, 8'h70, 8'h00, 8'h00}, e, 0);
         check("write address", wa, 16'h0002);
         check("write value", wf, 32'h42700000);
      end
      e = {};
      run({own_addr ^ 8'h01, 8'h04, 8'h00, 8'h00, 8'h00, 8'h02}, e, 0);
      run({8'h00, 8'h04, 8'h00, 8'h00, 8'h00, 8'h02}, e, 0);
      for (int md = 1; md < 3; md++) run({own_addr, 8'h04, 8'h00, 8'h00, 8'h00, 8'h02}, e, md);
      own_addr = 8'h00;
      run({8'h00, 8'h04, 8'h00, 8'h00, 8'h00, 8'h02}, e, 0);
      finish_test();
   end
endmodule // testbench
